// ==== src/osd_defines.vh ====
// Register offsets, field positions, reset values and timing for the oscillator switch block
`ifndef OSD_DEFINES_VH
`define OSD_DEFINES_VH

// Register byte offsets
`define OSD_OSC_CONTROL_REG_OFF   12'h000
`define OSD_CLOCK_DIVIDE_CTRL_OFF 12'h004
`define OSD_FAST_OSC_TUNE_OFF     12'h008
`define OSD_OSC_STATUS_OFF        12'h00c

// Control register fields
`define OSD_CUR_SRC_LSB   12
`define OSD_NEXT_SRC_LSB  8
`define OSD_FREEZE_BIT    7
`define OSD_PLL_LOCK_BIT  5
`define OSD_FAIL_BIT      3
`define OSD_SEC_EN_BIT    1
`define OSD_SWREQ_BIT     0

// Divide register fields
`define OSD_ROI_BIT       15
`define OSD_RATIO_LSB     12
`define OSD_RATIO_EN_BIT  11
`define OSD_POST_LSB      8
`define OSD_USBDIV_LSB    6

// Unlock keys
`define OSD_KEY_HI1       8'h78
`define OSD_KEY_HI2       8'h9a
`define OSD_KEY_LO1       8'h46
`define OSD_KEY_LO2       8'h57

// Source codes
`define OSD_SRC_FRC       3'h0
`define OSD_SRC_FAST_INTERNAL_RC_WITH_PLL    3'h1
`define OSD_SRC_PRI       3'h2
`define OSD_SRC_PRIPLL    3'h3
`define OSD_SRC_SEC       3'h4
`define OSD_SRC_LOW_POWER_INTERNAL_OSC      3'h5
`define OSD_SRC_RSVD      3'h6
`define OSD_SRC_FRCDIV    3'h7

// Reset values
`define OSD_DIV_RESET     16'h0000
`define OSD_TUNE_RESET    6'h00

// Handover count in new-clock cycles
`define OSD_HANDOVER_CYC  4'ha
`endif

// ==== src/osd_osc_switch.v ====
// Oscillator switch sequencer, clock dividers and tune register with APB slave
//
// What this block does
// - Interrupt with recover bit clears ratio enable
// - Ratio 1:2^code when enabled, else 1:1
// - Trim response may be nonlinear, non-monotonic
// - Switch among primary, secondary, fast, low-power
// - Primary submode fixed by fuse only
// - Switching enabled only when fuse is zero
// - Disabled: next field ignored, current from fuse
// - Disabled: switch request ignores writes, reads zero
// - High byte keys 78h,9Ah then next write
// - Low byte keys 46h,57h then request write
// - Equal current and next aborts the request
// - Valid switch clears lock and fail flags
// - Start new source, wait timer or lock
// - Count ten new-clock cycles before handover
// - Handover clears request, copies next to current
// - Old source off unless kept by watchdog/enable
// - Sequencer never stalls the core
// - Three-bit source code map
// - Lock bit reflects PLL lock only while a PLL source is selected
// - Freeze bit blocks switches with monitor enabled
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "osd_defines.vh"

module osd_osc_switch #(
  parameter TUNE_W = 6
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Configuration fuses
  input  wire        switch_fuse_n,
  input  wire        monitor_fuse_n,
  input  wire [2:0]  initial_source_fuse,
  input  wire [1:0]  primary_submode_fuse,
  input  wire        watchdog_en,
  // Oscillator status and events
  input  wire        irq_event,
  input  wire        new_clk_tick,
  input  wire        osc_startup_done,
  input  wire        pll_locked,
  input  wire        clock_fail_event,
  // Clock control outputs
  output reg  [2:0]  sys_source,
  output reg  [1:0]  primary_submode,
  output reg  [4:0]  osc_run,
  output reg  [7:0]  periph_ratio_div,
  output reg  [8:0]  fast_rc_div,
  output reg  [3:0]  usb_sysclk_div,
  output reg  [TUNE_W-1:0] fast_osc_trim,
  output reg         switch_busy
);

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  localparam ST_IDLE  = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_COUNT = 2'd2;

  localparam LK_NONE = 2'd0;
  localparam LK_ONE  = 2'd1;
  localparam LK_OPEN = 2'd2;

  // Oscillator run bits: 0 fast, 1 primary, 2 secondary, 3 low-power, 4 pll
  function [4:0] src_needs;
    input [2:0] s;
    begin
      case (s)
        `OSD_SRC_FRC:    src_needs = 5'h01;
        `OSD_SRC_FRCDIV: src_needs = 5'h01;
        `OSD_SRC_FAST_INTERNAL_RC_WITH_PLL: src_needs = 5'h11;
        `OSD_SRC_PRI:    src_needs = 5'h02;
        `OSD_SRC_PRIPLL: src_needs = 5'h12;
        `OSD_SRC_SEC:    src_needs = 5'h04;
        `OSD_SRC_LOW_POWER_INTERNAL_OSC:   src_needs = 5'h08;
        default:         src_needs = 5'h01;
      endcase
    end
  endfunction

  function src_uses_pll;
    input [2:0] s;
    begin
      src_uses_pll = (s == `OSD_SRC_FAST_INTERNAL_RC_WITH_PLL) || (s == `OSD_SRC_PRIPLL);
    end
  endfunction

  function src_is_xtal;
    input [2:0] s;
    begin
      src_is_xtal = (s == `OSD_SRC_PRI) || (s == `OSD_SRC_PRIPLL) ||
                    (s == `OSD_SRC_SEC);
    end
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg [2:0]  cur_src_q;
  reg [2:0]  next_src_q;
  reg        swreq_q;
  reg        freeze_q;
  reg        fail_q;
  reg        sec_en_q;
  reg        lock_clr_q;
  reg [1:0]  st_q;
  reg [3:0]  cnt_q;
  reg [1:0]  hi_lk_q;
  reg [1:0]  lo_lk_q;
  reg        roi_q;
  reg [2:0]  ratio_q;
  reg        ratio_en_q;
  reg [2:0]  post_q;
  reg [1:0]  usbdiv_q;
  reg [TUNE_W-1:0] tune_q;
  reg        init_q;

  wire sw_en     = ~switch_fuse_n;
  wire mon_en    = ~switch_fuse_n & ~monitor_fuse_n;
  wire frozen    = freeze_q & mon_en;
  wire wr_acc    = psel & penable & pwrite;
  wire hit_ctl   = (paddr == `OSD_OSC_CONTROL_REG_OFF);
  wire hit_div   = (paddr == `OSD_CLOCK_DIVIDE_CTRL_OFF);
  wire hit_tune  = (paddr == `OSD_FAST_OSC_TUNE_OFF);
  wire hit_stat  = (paddr == `OSD_OSC_STATUS_OFF);
  wire mapped    = hit_ctl | hit_div | hit_tune | hit_stat;
  wire ctl_wr    = wr_acc & hit_ctl;
  wire pll_ok    = pll_locked & ~lock_clr_q & src_uses_pll(sys_source);
  wire new_ready = (~src_is_xtal(next_src_q) | osc_startup_done) &
                   (~src_uses_pll(next_src_q) | pll_locked);

  // ------------------------------------------------------------
  // Unlock tracking and control register
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      cur_src_q  <= `OSD_SRC_FRCDIV;
      next_src_q <= `OSD_SRC_FRCDIV;
      swreq_q    <= 1'b0;
      freeze_q   <= 1'b0;
      fail_q     <= 1'b0;
      sec_en_q   <= 1'b0;
      lock_clr_q <= 1'b0;
      hi_lk_q    <= LK_NONE;
      lo_lk_q    <= LK_NONE;
      st_q       <= ST_IDLE;
      cnt_q      <= 4'h0;
      init_q     <= 1'b1;
    end else begin
      // Fuse capture after reset release
      if (init_q) begin
        init_q     <= 1'b0;
        cur_src_q  <= initial_source_fuse;
        next_src_q <= initial_source_fuse;
      end
      // Each control register write is one instruction for key sequencing
      if (ctl_wr) begin
        if (pwdata[15:8] == `OSD_KEY_HI1)
          hi_lk_q <= LK_ONE;
        else if (pwdata[15:8] == `OSD_KEY_HI2 && hi_lk_q == LK_ONE)
          hi_lk_q <= LK_OPEN;
        else
          hi_lk_q <= LK_NONE;
        if (pwdata[7:0] == `OSD_KEY_LO1)
          lo_lk_q <= LK_ONE;
        else if (pwdata[7:0] == `OSD_KEY_LO2 && lo_lk_q == LK_ONE)
          lo_lk_q <= LK_OPEN;
        else
          lo_lk_q <= LK_NONE;
        if (hi_lk_q == LK_OPEN && sw_en && !frozen && st_q == ST_IDLE)
          next_src_q <= pwdata[10:8];
        if (lo_lk_q == LK_OPEN) begin
          sec_en_q <= pwdata[`OSD_SEC_EN_BIT];
          if (pwdata[`OSD_FREEZE_BIT])
            freeze_q <= 1'b1;
          if (pwdata[`OSD_FAIL_BIT] == 1'b0)
            fail_q <= 1'b0;
          if (pwdata[`OSD_SWREQ_BIT] && sw_en && !frozen && st_q == ST_IDLE)
            swreq_q <= 1'b1;
        end
      end
      if (!src_uses_pll(sys_source))
        lock_clr_q <= 1'b0;
      // Sequencer runs beside the core, never holds pready
      case (st_q)
        ST_IDLE: begin
          if (swreq_q) begin
            if (next_src_q == cur_src_q) begin
              swreq_q <= 1'b0;
            end else begin
              fail_q     <= 1'b0;
              lock_clr_q <= 1'b1;
              st_q       <= ST_START;
            end
          end
        end
        ST_START: begin
          if (new_ready) begin
            st_q  <= ST_COUNT;
            cnt_q <= 4'h0;
          end
        end
        ST_COUNT: begin
          if (new_clk_tick) begin
            if (cnt_q == `OSD_HANDOVER_CYC - 4'h1) begin
              cur_src_q  <= next_src_q;
              swreq_q    <= 1'b0;
              lock_clr_q <= 1'b0;
              st_q       <= ST_IDLE;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      // Fail event beats same-cycle clears
      if (clock_fail_event && mon_en)
        fail_q <= 1'b1;
      if (!sw_en)
        swreq_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Divide and tune registers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      roi_q      <= 1'b0;
      ratio_q    <= 3'h0;
      ratio_en_q <= 1'b0;
      post_q     <= 3'h0;
      usbdiv_q   <= 2'h0;
      tune_q     <= `OSD_TUNE_RESET;
    end else begin
      if (wr_acc && hit_div) begin
        roi_q      <= pwdata[`OSD_ROI_BIT];
        ratio_q    <= pwdata[`OSD_RATIO_LSB +: 3];
        ratio_en_q <= pwdata[`OSD_RATIO_EN_BIT];
        post_q     <= pwdata[`OSD_POST_LSB +: 3];
        usbdiv_q   <= pwdata[`OSD_USBDIV_LSB +: 2];
      end
      // Interrupt wins over a same-cycle write
      if (irq_event && roi_q)
        ratio_en_q <= 1'b0;
      if (wr_acc && hit_tune)
        tune_q <= pwdata[TUNE_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      sys_source       <= `OSD_SRC_FRCDIV;
      primary_submode  <= 2'h0;
      osc_run          <= 5'h01;
      periph_ratio_div <= 8'h01;
      fast_rc_div      <= 9'h001;
      usb_sysclk_div   <= 4'h1;
      fast_osc_trim    <= `OSD_TUNE_RESET;
      switch_busy      <= 1'b0;
    end else begin
      sys_source      <= cur_src_q;
      primary_submode <= primary_submode_fuse;
      // Keep the new source running while switching, old one drops after
      osc_run <= src_needs(cur_src_q) |
                 ((st_q != ST_IDLE) ? src_needs(next_src_q) : 5'h00) |
                 {1'b0, watchdog_en | mon_en, sec_en_q, 2'b00};
      periph_ratio_div <= ratio_en_q ? (8'h01 << ratio_q) : 8'h01;
      fast_rc_div      <= (post_q == 3'h7) ? 9'h100 : (9'h001 << post_q);
      usb_sysclk_div   <= 4'h1 << usbdiv_q;
      // Trim passed through unchanged; response is analog's concern
      fast_osc_trim    <= tune_q;
      switch_busy      <= (st_q != ST_IDLE);
    end
  end

  // ------------------------------------------------------------
  // APB slave: one wait-free access phase
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= 32'h0;
      if (psel && !penable) begin
        if (hit_ctl)
          prdata <= {17'h0, cur_src_q, 1'b0, next_src_q, freeze_q, 1'b0,
                     pll_ok, 1'b0, fail_q, 1'b0, sec_en_q, swreq_q};
        else if (hit_div)
          prdata <= {16'h0, roi_q, ratio_q, ratio_en_q, post_q, usbdiv_q, 6'h0};
        else if (hit_tune)
          prdata <= {{(32-TUNE_W){1'b0}}, tune_q};
        else if (hit_stat)
          prdata <= {26'h0, st_q, hi_lk_q, lo_lk_q};
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/osd_osc_switch_properties.sv ====
// Port-level properties of the oscillator switch block
`timescale 1ns/1ps
`default_nettype none
module osd_osc_switch_properties (
  // Clock, reset and bus
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // Fuses and oscillator status
  input wire logic       switch_fuse_n,
  input wire logic       new_clk_tick,
  input wire logic       osc_startup_done,
  input wire logic       pll_locked,
  // Clock control outputs
  input wire logic [2:0] sys_source,
  input wire logic [7:0] periph_ratio_div,
  input wire logic [8:0] fast_rc_div,
  input wire logic [3:0] usb_sysclk_div,
  input wire logic       switch_busy
);
  logic [1:0] up_q;
  logic [3:0] tk_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // --------------------------------
  // Edges since reset, ready ticks
  // --------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      up_q <= 2'h0;
      tk_q <= 4'h0;
    end else begin
      if (up_q != 2'h3) up_q <= up_q + 2'h1;
      if (!switch_busy) tk_q <= 4'h0;
      else if (new_clk_tick && osc_startup_done && pll_locked) tk_q <= tk_q + 4'h1;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    $fell(switch_busy) && tk_q == 4'ha;
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing in access cycle");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_fuse_no_busy: assert property (up_q == 2'h3 && switch_fuse_n |-> !switch_busy)
    else $error("sequencer ran with switching off");
  chk_fuse_holds_src: assert property (up_q == 2'h3 && switch_fuse_n |=> $stable(sys_source))
    else $error("source moved with switching off");
  chk_ratio_pow_two: assert property ($onehot(periph_ratio_div))
    else $error("ratio not a power of two");
  chk_post_range: assert property ($onehot(fast_rc_div) && !fast_rc_div[7])
    else $error("postscaler divide out of set");
  chk_usb_pow_two: assert property ($onehot(usb_sysclk_div))
    else $error("usb divide out of set");
  chk_ten_ticks: assert property ($fell(switch_busy) |-> tk_q == 4'ha)
    else $error("handover not after ten ticks");
  chk_src_follows: assert property (s_done |-> ##[0:3] $changed(sys_source))
    else $error("source not updated after handover");
endmodule
bind osd_osc_switch osd_osc_switch_properties u_chk (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
  .switch_fuse_n(switch_fuse_n), .new_clk_tick(new_clk_tick),
  .osc_startup_done(osc_startup_done), .pll_locked(pll_locked),
  .sys_source(sys_source), .periph_ratio_div(periph_ratio_div),
  .fast_rc_div(fast_rc_div), .usb_sysclk_div(usb_sysclk_div),
  .switch_busy(switch_busy)
);
`default_nettype wire

// ==== verification/test_osc_switch_and_clock_divide.sv ====
// Self-checking bench for the oscillator switch block
`timescale 1ns/1ps
`default_nettype none
`include "osd_defines.vh"
module test_osc_switch_and_clock_divide;
  logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, switch_busy;
  logic        switch_fuse_n = 0, monitor_fuse_n = 0, watchdog_en = 1;
  logic [2:0]  initial_source_fuse = 3'h7, sys_source, cur;
  logic [1:0]  primary_submode_fuse = 2'h1, primary_submode;
  logic        irq_event = 0, new_clk_tick = 0, clock_fail_event = 0;
  logic        osc_startup_done = 1, pll_locked = 1;
  logic [4:0]  osc_run;
  logic [7:0]  periph_ratio_div;
  logic [8:0]  fast_rc_div;
  logic [3:0]  usb_sysclk_div;
  logic [5:0]  fast_osc_trim;
  logic [15:0] d = 16'h0054, v;
  logic [2:0]  seq [9] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h4, 3'h5, 3'h5, 3'h0, 3'h7};
  int          num_errors = 0, total_checks = 0;
  osd_osc_switch DUT (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_fuse_n(switch_fuse_n), .monitor_fuse_n(monitor_fuse_n),
    .initial_source_fuse(initial_source_fuse), .primary_submode_fuse(primary_submode_fuse),
    .watchdog_en(watchdog_en), .irq_event(irq_event), .new_clk_tick(new_clk_tick),
    .osc_startup_done(osc_startup_done), .pll_locked(pll_locked),
    .clock_fail_event(clock_fail_event), .sys_source(sys_source),
    .primary_submode(primary_submode), .osc_run(osc_run),
    .periph_ratio_div(periph_ratio_div), .fast_rc_div(fast_rc_div),
    .usb_sysclk_div(usb_sysclk_div), .fast_osc_trim(fast_osc_trim),
    .switch_busy(switch_busy)
  );
  initial forever #5 clk = ~clk;
  // --------------------------------
  // Tasks
  // --------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Oscillators expected running once settled on source s
  function automatic logic [4:0] run_exp(input logic [2:0] s);
    return {s == `OSD_SRC_FAST_INTERNAL_RC_WITH_PLL || s == `OSD_SRC_PRIPLL, 1'b1, s == `OSD_SRC_SEC,
            s == `OSD_SRC_PRI || s == `OSD_SRC_PRIPLL,
            s == `OSD_SRC_FRC || s == `OSD_SRC_FAST_INTERNAL_RC_WITH_PLL || s == `OSD_SRC_FRCDIV};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [15:0] x);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, x};
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic reset(input logic [2:0] f, input logic dis);
    sys_rst <= 1;
    initial_source_fuse <= f;
    switch_fuse_n <= dis;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    repeat (3) @(posedge clk);
    cur = f;
    chk("src", sys_source, f);
  endtask
  task automatic irq;
    irq_event <= 1;
    @(posedge clk);
    irq_event <= 0;
    repeat (2) @(posedge clk);
  endtask
  task automatic sw(input logic [2:0] s, input logic ok);
    int n;
    osc_startup_done <= 0;
    pll_locked <= (s != `OSD_SRC_FAST_INTERNAL_RC_WITH_PLL);
    irq_event <= 0;
    clock_fail_event <= 1;
    @(posedge clk);
    clock_fail_event <= 0;
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, 16'h7800);
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, 16'h9a00);
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, {5'h0, s, 8'h0});
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, 16'h0046);
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, 16'h0057);
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, 16'h0009);
    apb(`OSD_OSC_CONTROL_REG_OFF, 0, 16'h0);
    chk("busy", switch_busy, ok);
    if (ok) chk("lock fail", rd[5:3], 3'h0);
    osc_startup_done <= 1;
    pll_locked <= 1;
    for (n = 0; n < 60 && switch_busy !== 1'b0; n++) begin
      new_clk_tick <= n[0];
      @(posedge clk);
    end
    new_clk_tick <= 0;
    repeat (2) @(posedge clk);
    if (ok) cur = s;
    apb(`OSD_OSC_CONTROL_REG_OFF, 0, 16'h0);
    chk("req", rd[0], 1'b0);
    chk("cur", rd[14:12], cur);
    chk("lock", rd[5], cur == `OSD_SRC_FAST_INTERNAL_RC_WITH_PLL || cur == `OSD_SRC_PRIPLL);
    chk("src", sys_source, cur);
    if (ok) chk("run", osc_run, run_exp(s));
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // --------------------------------
  // Sequence
  // --------------------------------
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  initial begin
    reset(`OSD_SRC_FRCDIV, 0);
    chk("submode", primary_submode, 2'h1);
    apb(12'h010, 0, 16'h0);
    chk("unmapped err", er, 1'b1);
    chk("unmapped rd", rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      d = lfsr(d);
      v = i < 8 ? {1'b0, i[2:0], 1'b1, i[2:0], i[1:0], 6'h0} : d & 16'h7fff;
      apb(`OSD_CLOCK_DIVIDE_CTRL_OFF, 1, v);
      apb(`OSD_CLOCK_DIVIDE_CTRL_OFF, 0, 16'h0);
      chk("div", rd, v & 16'hffc0);
      chk("ratio", periph_ratio_div, v[11] ? 8'h1 << v[14:12] : 8'h1);
      chk("post", fast_rc_div, &v[10:8] ? 9'h100 : 9'h1 << v[10:8]);
      chk("usb", usb_sysclk_div, 4'h1 << v[7:6]);
    end
    apb(`OSD_CLOCK_DIVIDE_CTRL_OFF, 1, 16'hd800);
    irq();
    apb(`OSD_CLOCK_DIVIDE_CTRL_OFF, 0, 16'h0);
    chk("roi", rd, 32'hd000);
    chk("ratio", periph_ratio_div, 8'h1);
    apb(`OSD_CLOCK_DIVIDE_CTRL_OFF, 1, 16'h3800);
    irq();
    chk("ratio", periph_ratio_div, 8'h8);
    for (int i = 0; i < 4; i++) begin
      d = lfsr(d);
      v = i == 0 ? 16'hffdf : i == 1 ? 16'h0020 : d;
      apb(`OSD_FAST_OSC_TUNE_OFF, 1, v);
      apb(`OSD_FAST_OSC_TUNE_OFF, 0, 16'h0);
      chk("tune", rd, v[5:0]);
      chk("trim", fast_osc_trim, v[5:0]);
    end
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, 16'h7800);
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, 16'h0000);
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, 16'h9a00);
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, 16'h0200);
    apb(`OSD_OSC_CONTROL_REG_OFF, 0, 16'h0);
    chk("next", rd[10:8], `OSD_SRC_FRCDIV);
    foreach (seq[i]) sw(seq[i], seq[i] != cur);
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, 16'h0046);
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, 16'h0057);
    apb(`OSD_OSC_CONTROL_REG_OFF, 1, 16'h0080);
    sw(`OSD_SRC_PRI, 0);
    reset(`OSD_SRC_SEC, 1);
    sw(`OSD_SRC_PRI, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
